// ===== src/low_rate_output_clock_gen.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module low_rate_output_clock_gen #(
  parameter int SRC_HZ = low_rate_clk_pkg::SRC_HZ_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [low_rate_clk_pkg::ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire low_rate_clk_pkg::src_ticks_t srcTicks,
  input wire logic secRefValid,
  input wire logic pulse_width_ref_clk,
  output logic composite_clk_out,
  output logic ds1_e1_clk_out,
  output logic sync_8k_out,
  output logic sync_2k_out
);
  import low_rate_clk_pkg::*;

  localparam int COMP_PERIOD = SRC_HZ / COMPOSITE_HZ;
  localparam int FRAME8_PERIOD = int'((longint'(SRC_HZ) * FRAME_8K_US) / 1_000_000);
  localparam int FRAMES_PER_2K = FRAME_2K_US / FRAME_8K_US;
  localparam logic [NCO_WIDTH-1:0] INC_DS1 =
    NCO_WIDTH'((longint'(DS1_HZ) << NCO_WIDTH) / SRC_HZ);
  localparam logic [NCO_WIDTH-1:0] INC_E1 =
    NCO_WIDTH'((longint'(E1_HZ) << NCO_WIDTH) / SRC_HZ);
  localparam int CW = $clog2(COMP_PERIOD);
  localparam int FW = $clog2(FRAME8_PERIOD);
  localparam int QW = $clog2(FRAMES_PER_2K);
  localparam logic [CW-1:0] COMP_LAST = CW'(COMP_PERIOD - 1);
  localparam logic [CW-1:0] COMP_HALF = CW'(COMP_PERIOD / 2);
  localparam logic [FW-1:0] FRAME8_LAST = FW'(FRAME8_PERIOD - 1);
  localparam logic [FW-1:0] FRAME8_HALF = FW'(FRAME8_PERIOD / 2);
  localparam logic [QW-1:0] Q2K_LAST = QW'(FRAMES_PER_2K - 1);
  localparam logic [QW-1:0] Q2K_HALF = QW'(FRAMES_PER_2K / 2);

  path_cfg_t pathCfg_q;
  out_ctrl_t outCtrl_q;
  fsync_cfg_t fsyncCfg_q;
  logic waitReq_q;
  logic [31:0] rdData_q;

  // Register bus: one wait cycle, then the access completes
  logic accept;
  logic [31:0] statusWord;
  logic [31:0] rdMux;
  assign accept = (avs_read | avs_write) & ~waitReq_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      waitReq_q <= 1'b1;
    end else if (accept) begin
      waitReq_q <= 1'b1;
    end else if (avs_read | avs_write) begin
      waitReq_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pathCfg_q <= path_cfg_t'(PATH_CFG_RESET[3:0]);
      outCtrl_q <= out_ctrl_t'(OUT_CTRL_RESET[2:0]);
      fsyncCfg_q <= fsync_cfg_t'(FSYNC_CFG_RESET[3:0]);
    end else if (accept && avs_write && avs_byteenable[0]) begin
      // All fields sit in byte lane 0; upper lanes hold no bits
      case (avs_address)
        ADDR_PATH_CFG: pathCfg_q <= path_cfg_t'(avs_writedata[3:0]);
        ADDR_OUT_CTRL: outCtrl_q <= out_ctrl_t'(avs_writedata[2:0]);
        ADDR_FSYNC_CFG: fsyncCfg_q <= fsync_cfg_t'(avs_writedata[3:0]);
        default: begin
        end
      endcase
    end
  end

  logic squelch;
  logic compRun_q;
  logic ds1e1Run_q;
  logic run8_q;
  logic run2_q;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_SQUELCH_BIT] = squelch;
    statusWord[ST_COMP_RUN_BIT] = compRun_q;
    statusWord[ST_DS1E1_RUN_BIT] = ds1e1Run_q;
    statusWord[ST_SYNC8K_RUN_BIT] = run8_q;
    statusWord[ST_SYNC2K_RUN_BIT] = run2_q;
    statusWord[ST_SEC_VALID_BIT] = secRefValid;
    case (avs_address)
      ADDR_PATH_CFG: rdMux = {28'h000_0000, pathCfg_q};
      ADDR_OUT_CTRL: rdMux = {29'h000_0000, outCtrl_q};
      ADDR_FSYNC_CFG: rdMux = {28'h000_0000, fsyncCfg_q};
      ADDR_STATUS: rdMux = statusWord;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Captured during the wait cycle so data stand at the completing edge
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdData_q <= 32'h0000_0000;
    end else if (avs_read && waitReq_q) begin
      rdData_q <= rdMux;
    end
  end

  assign avs_readdata = rdData_q;
  assign avs_waitrequest = waitReq_q;

  // Source path for composite and DS1/E1
  logic srcTick;
  logic rateIsDs1;
  assign srcTick = (pathCfg_q.lowRatePathSel == PATH_PRIMARY) ? srcTicks.priTick
                                                              : srcTicks.secTick;
  assign squelch = (pathCfg_q.lowRatePathSel != PATH_PRIMARY) & pathCfg_q.autoSquelchEn
                   & ~secRefValid;
  assign rateIsDs1 = (pathCfg_q.lowRatePathSel == PATH_PRIMARY)
                     ? (pathCfg_q.rateStandardSel == RATE_DS1)
                     : (pathCfg_q.ds1e1RateSelSec == RATE_DS1);

  // Composite clock by integer division
  logic [CW-1:0] compCnt_q;
  logic compWrap;
  logic compOut_q;
  assign compWrap = srcTick && (compCnt_q == COMP_LAST);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      compCnt_q <= '0;
    end else if (srcTick) begin
      compCnt_q <= compWrap ? '0 : compCnt_q + CW'(1);
    end
  end

  // Squelch stops at once; restart waits for a period boundary
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      compRun_q <= 1'b0;
    end else if (squelch) begin
      compRun_q <= 1'b0;
    end else if (compWrap) begin
      compRun_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      compOut_q <= 1'b0;
    end else begin
      compOut_q <= compRun_q & ~squelch & (compCnt_q < COMP_HALF);
    end
  end

  // DS1/E1 clock by synthesis
  logic ncoMsb;
  logic ncoWrap;
  logic ds1e1Out_q;

  nco_synth #(
    .WIDTH(NCO_WIDTH)
  ) u_nco (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(srcTick),
    .inc(rateIsDs1 ? INC_DS1 : INC_E1),
    .msb(ncoMsb),
    .wrap(ncoWrap)
  );

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ds1e1Run_q <= 1'b0;
    end else if (!outCtrl_q.ds1e1OutEn || squelch) begin
      ds1e1Run_q <= 1'b0;
    end else if (ncoWrap) begin
      ds1e1Run_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ds1e1Out_q <= 1'b0;
    end else begin
      ds1e1Out_q <= ds1e1Run_q & ~squelch & outCtrl_q.ds1e1OutEn & ncoMsb;
    end
  end

  // Frame timing always from the primary path
  logic [FW-1:0] frameCnt_q;
  logic [QW-1:0] quadCnt_q;
  logic frame8Wrap;
  logic frame2Wrap;
  assign frame8Wrap = srcTicks.priTick && (frameCnt_q == FRAME8_LAST);
  assign frame2Wrap = frame8Wrap && (quadCnt_q == Q2K_LAST);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frameCnt_q <= '0;
    end else if (srcTicks.priTick) begin
      frameCnt_q <= frame8Wrap ? '0 : frameCnt_q + FW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      quadCnt_q <= '0;
    end else if (frame8Wrap) begin
      quadCnt_q <= frame2Wrap ? '0 : quadCnt_q + QW'(1);
    end
  end

  // Width clock comes from another block's pin; synchronise first
  logic pwSync1_q;
  logic pwSync2_q;
  logic pwPrev_q;
  logic pwRise;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pwSync1_q <= 1'b0;
      pwSync2_q <= 1'b0;
      pwPrev_q <= 1'b0;
    end else begin
      pwSync1_q <= pulse_width_ref_clk;
      pwSync2_q <= pwSync1_q;
      pwPrev_q <= pwSync2_q;
    end
  end
  assign pwRise = pwSync2_q & ~pwPrev_q;

  // Pulse engines: a frame boundary arms, the next width edge opens, the one after closes
  logic pend8_q;
  logic low8_q;
  logic pend2_q;
  logic low2_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend8_q <= 1'b0;
      low8_q <= 1'b0;
    end else begin
      if (frame8Wrap) begin
        pend8_q <= 1'b1;
      end else if (pwRise && !low8_q) begin
        pend8_q <= 1'b0;
      end
      if (pwRise) begin
        low8_q <= ~low8_q & pend8_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend2_q <= 1'b0;
      low2_q <= 1'b0;
    end else begin
      if (frame2Wrap) begin
        pend2_q <= 1'b1;
      end else if (pwRise && !low2_q) begin
        pend2_q <= 1'b0;
      end
      if (pwRise) begin
        low2_q <= ~low2_q & pend2_q;
      end
    end
  end

  // Enables take hold on frame boundaries only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run8_q <= 1'b0;
    end else if (!outCtrl_q.sync8kOutEn) begin
      run8_q <= 1'b0;
    end else if (frame8Wrap) begin
      run8_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run2_q <= 1'b0;
    end else if (!outCtrl_q.sync2kOutEn) begin
      run2_q <= 1'b0;
    end else if (frame2Wrap) begin
      run2_q <= 1'b1;
    end
  end

  logic sq8;
  logic sq2;
  logic lvl8;
  logic lvl2;
  logic sync8Out_q;
  logic sync2Out_q;
  assign sq8 = frameCnt_q < FRAME8_HALF;
  assign sq2 = quadCnt_q < Q2K_HALF;
  // Pulse mode assumes the width clock is fast and from the primary path
  assign lvl8 = fsyncCfg_q.sync8kPulseMode ? ~low8_q : sq8;
  assign lvl2 = fsyncCfg_q.sync2kPulseMode ? ~low2_q : sq2;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync8Out_q <= 1'b0;
      sync2Out_q <= 1'b0;
    end else begin
      sync8Out_q <= run8_q & (lvl8 ^ fsyncCfg_q.sync8kInvert);
      sync2Out_q <= run2_q & (lvl2 ^ fsyncCfg_q.sync2kInvert);
    end
  end

  assign composite_clk_out = compOut_q;
  assign ds1_e1_clk_out = ds1e1Out_q;
  assign sync_8k_out = sync8Out_q;
  assign sync_2k_out = sync2Out_q;
endmodule : low_rate_output_clock_gen

// ===== src/low_rate_clk_pkg.sv
package low_rate_clk_pkg;

  // Nominal rate of the source synthesis input clock, as source ticks per second
  localparam int SRC_HZ_DEFAULT = 12_288_000;
  localparam int COMPOSITE_HZ = 64_000;
  localparam int DS1_HZ = 1_544_000;
  localparam int E1_HZ = 2_048_000;
  localparam int FRAME_8K_US = 125;
  localparam int FRAME_2K_US = 500;
  localparam int NCO_WIDTH = 32;

  // Avalon-MM register map, byte addresses
  localparam int ADDR_WIDTH = 4;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PATH_CFG = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] ADDR_OUT_CTRL = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] ADDR_FSYNC_CFG = 4'h8;
  localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 4'hC;

  // Path configuration fields
  localparam int PATH_SEL_BIT = 0;
  localparam int SQUELCH_EN_BIT = 1;
  localparam int RATE_SEC_BIT = 2;
  localparam int RATE_STD_BIT = 3;
  // Output control fields
  localparam int DS1E1_EN_BIT = 0;
  localparam int SYNC8K_EN_BIT = 1;
  localparam int SYNC2K_EN_BIT = 2;
  // Frame sync fields
  localparam int PUL8K_BIT = 0;
  localparam int INV8K_BIT = 1;
  localparam int PUL2K_BIT = 2;
  localparam int INV2K_BIT = 3;
  // Status fields
  localparam int ST_SQUELCH_BIT = 0;
  localparam int ST_COMP_RUN_BIT = 1;
  localparam int ST_DS1E1_RUN_BIT = 2;
  localparam int ST_SYNC8K_RUN_BIT = 3;
  localparam int ST_SYNC2K_RUN_BIT = 4;
  localparam int ST_SEC_VALID_BIT = 5;

  localparam logic [31:0] PATH_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] OUT_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FSYNC_CFG_RESET = 32'h0000_0000;

  // Rate bit value meaning DS1; the other value selects E1
  localparam logic RATE_DS1 = 1'b1;
  localparam logic PATH_PRIMARY = 1'b1;

  typedef struct packed {
    logic rateStandardSel;
    logic ds1e1RateSelSec;
    logic autoSquelchEn;
    logic lowRatePathSel;
  } path_cfg_t;

  typedef struct packed {
    logic sync2kOutEn;
    logic sync8kOutEn;
    logic ds1e1OutEn;
  } out_ctrl_t;

  typedef struct packed {
    logic sync2kInvert;
    logic sync2kPulseMode;
    logic sync8kInvert;
    logic sync8kPulseMode;
  } fsync_cfg_t;

  typedef struct packed {
    logic priTick;
    logic secTick;
  } src_ticks_t;

endpackage : low_rate_clk_pkg

// ===== src/nco_synth.sv
`timescale 1ns/1ps
// Phase accumulator; fractional ratios give a synthesized, not divided, clock
module nco_synth #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic [WIDTH-1:0] inc,
  output logic msb,
  output logic wrap
);
  logic [WIDTH-1:0] phase_q;
  logic [WIDTH:0] sum;

  assign sum = {1'b0, phase_q} + {1'b0, inc};
  assign msb = phase_q[WIDTH-1];
  assign wrap = tick & sum[WIDTH];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      phase_q <= '0;
    end else if (tick) begin
      phase_q <= sum[WIDTH-1:0];
    end
  end
endmodule : nco_synth

// ===== sim/lrc_props.sv
`timescale 1ns/1ps
module lrc_props #(
  parameter int SRC_HZ = low_rate_clk_pkg::SRC_HZ_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [low_rate_clk_pkg::ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire low_rate_clk_pkg::src_ticks_t srcTicks,
  input wire logic secRefValid,
  input wire logic pulse_width_ref_clk,
  input wire logic composite_clk_out,
  input wire logic ds1_e1_clk_out,
  input wire logic sync_8k_out,
  input wire logic sync_2k_out
);
  import low_rate_clk_pkg::*;
  localparam int CH = SRC_HZ / (2 * COMPOSITE_HZ);
  localparam int H8 = SRC_HZ / 16_000;
  localparam int SETTLE = SRC_HZ / 1_000;
  // The 8k output is clean two of its frames after a write
  localparam int SETTLE8 = SRC_HZ / 4_000;
  logic [3:0] path_q, fs_q;
  logic [2:0] en_q;
  logic [15:0] age_q, compTk_q, tk8_q;
  logic [7:0] w8_q, w2_q;
  logic arm_q, comp_q, s8_q, wPrev_q;
  wire logic wd = avs_write && !avs_waitrequest;
  wire logic wr = wd && avs_byteenable[0];
  wire logic sq = !path_q[PATH_SEL_BIT] && path_q[SQUELCH_EN_BIT] && !secRefValid;
  wire logic selTk = path_q[PATH_SEL_BIT] ? srcTicks.priTick : srcTicks.secTick;
  wire logic wRise = pulse_width_ref_clk && !wPrev_q;
  wire logic lv8 = sync_8k_out ^ fs_q[INV8K_BIT];
  wire logic lv2 = sync_2k_out ^ fs_q[INV2K_BIT];
  // Enables land on frame boundaries, so judge only long after any write
  wire logic settled = age_q > 16'(SETTLE);
  wire logic settled8 = age_q > 16'(SETTLE8);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      path_q <= '0;
      en_q <= '0;
      fs_q <= '0;
    end else if (wr && avs_address == ADDR_PATH_CFG) begin
      path_q <= avs_writedata[3:0];
    end else if (wr && avs_address == ADDR_OUT_CTRL) begin
      en_q <= avs_writedata[2:0];
    end else if (wr && avs_address == ADDR_FSYNC_CFG) begin
      fs_q <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || wd) begin
      age_q <= '0;
    end else if (!age_q[15]) begin
      age_q <= age_q + 16'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      comp_q <= 1'b0;
      s8_q <= 1'b0;
      wPrev_q <= 1'b0;
      arm_q <= 1'b0;
      compTk_q <= '0;
      tk8_q <= '0;
      w8_q <= '0;
      w2_q <= '0;
    end else begin
      comp_q <= composite_clk_out;
      s8_q <= sync_8k_out;
      wPrev_q <= pulse_width_ref_clk;
      compTk_q <= (composite_clk_out != comp_q) ? 16'(selTk) : compTk_q + 16'(selTk);
      tk8_q <= (sync_8k_out != s8_q) ? 16'(srcTicks.priTick) : tk8_q + 16'(srcTicks.priTick);
      arm_q <= !(wd || sq) && (arm_q || composite_clk_out != comp_q);
      w8_q <= lv8 ? '0 : w8_q + 8'(wRise);
      w2_q <= lv2 ? '0 : w2_q + 8'(wRise);
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  squelch_mute_a: assert property (sq [*3] |-> !composite_clk_out && !ds1_e1_clk_out)
    else $error("squelched output active");
  ds1_off_a: assert property (!en_q[DS1E1_EN_BIT] [*3] |-> !ds1_e1_clk_out)
    else $error("disabled rate clock active");
  sync8_off_a: assert property (!en_q[SYNC8K_EN_BIT] [*3] |-> !sync_8k_out)
    else $error("disabled 8k output active");
  sync2_off_a: assert property (!en_q[SYNC2K_EN_BIT] [*3] |-> !sync_2k_out)
    else $error("disabled 2k output active");
  comp_half_a: assert property (composite_clk_out != comp_q && arm_q |-> compTk_q == 16'(CH))
    else $error("composite half period");
  pulse8_span_a: assert property (
    $rose(lv8) && fs_q[PUL8K_BIT] && en_q[SYNC8K_EN_BIT] && settled8 |-> w8_q == 8'd1)
    else $error("8k pulse width");
  pulse2_span_a: assert property (
    $rose(lv2) && fs_q[PUL2K_BIT] && en_q[SYNC2K_EN_BIT] && settled |-> w2_q == 8'd1)
    else $error("2k pulse width");
  sq8_half_a: assert property (
    sync_8k_out != s8_q && !fs_q[PUL8K_BIT] && en_q[SYNC8K_EN_BIT] && settled8
    |-> tk8_q == 16'(H8))
    else $error("8k half period");
  cover property (sq [*8]);
  cover property ($rose(lv8) && fs_q[PUL8K_BIT] && settled);
  cover property ($rose(ds1_e1_clk_out));
endmodule : lrc_props

bind low_rate_output_clock_gen lrc_props #(.SRC_HZ(SRC_HZ)) u_props (.*);

// ===== sim/timing_peer_model.sv
`timescale 1ns/1ps
module timing_peer_model #(
  parameter real WIDTH_HALF = 20.0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  output low_rate_clk_pkg::src_ticks_t srcTicks,
  output logic pulse_width_ref_clk
);
  import low_rate_clk_pkg::*;
  logic secPhase_q;
  // Secondary at half rate so the chosen path shows in the periods
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      srcTicks <= '0;
      secPhase_q <= 1'b0;
    end else begin
      srcTicks <= '{priTick: 1'b1, secTick: secPhase_q};
      secPhase_q <= !secPhase_q;
    end
  end
  // Free-running 25 MHz width clock, phase unrelated to ref_clk
  initial begin
    pulse_width_ref_clk = 1'b0;
    #3.3;
    forever #(WIDTH_HALF) pulse_width_ref_clk = ~pulse_width_ref_clk;
  end
endmodule : timing_peer_model

// ===== sim/low_rate_output_clock_gen_tb.sv
`timescale 1ns/1ps
module low_rate_output_clock_gen_tb;
  import low_rate_clk_pkg::*;
  localparam int SRC = SRC_HZ_DEFAULT;
  localparam int H8 = SRC / 16_000;
  localparam int WCYC = 8;
  typedef struct {logic [31:0] val; logic [31:0] mask;} note_t;
  logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, secRefValid, pwClk;
  logic compOut, ds1Out, s8Out, s2Out;
  logic [ADDR_WIDTH-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rng;
  logic [3:0] avs_byteenable;
  src_ticks_t srcTicks;
  note_t notes[$];
  int badCount = 0;
  int nChecks = 0;
  wire logic [3:0] outs = {s2Out, s8Out, ds1Out, compOut};

  low_rate_output_clock_gen #(.SRC_HZ(SRC)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .srcTicks(srcTicks),
    .secRefValid(secRefValid), .pulse_width_ref_clk(pwClk), .composite_clk_out(compOut),
    .ds1_e1_clk_out(ds1Out), .sync_8k_out(s8Out), .sync_2k_out(s2Out));
  timing_peer_model u_peer (
    .ref_clk(ref_clk), .nrst(nrst), .srcTicks(srcTicks), .pulse_width_ref_clk(pwClk));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : nextRand

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic near(input int seen, input int exp);
    check({31'h0, seen >= exp - 2 && seen <= exp + 2}, 32'h1);
  endtask : near

  task automatic busReq(input logic [3:0] a, input logic rd, input logic [31:0] d,
                        input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : busReq

  task automatic rdExp(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    busReq(a, 1'b1, '0, 4'hF);
  endtask : rdExp

  // Length of the next full run at level lvl, in clock cycles
  task automatic span(input int i, input logic lvl, output int n);
    n = 0;
    while (outs[i] === lvl) @(posedge ref_clk);
    while (outs[i] !== lvl) @(posedge ref_clk);
    while (outs[i] === lvl) begin
      n++;
      @(posedge ref_clk);
    end
  endtask : span

  task automatic rises(input int i, input int cyc, output int n);
    logic p;
    n = 0;
    p = outs[i];
    repeat (cyc) begin
      @(posedge ref_clk);
      n += int'(outs[i] === 1'b1 && p === 1'b0);
      p = outs[i];
    end
  endtask : rises

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict

  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      check(avs_readdata & notes[0].mask, notes[0].val);
      void'(notes.pop_front());
    end
  end

  initial begin
    // Worst case of all phases is near 62k cycles
    #(95_000 * 5);
    badCount++;
    giveVerdict();
  end

  initial begin
    int n;
    logic [3:0] cfg;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = '0;
    secRefValid = 1'b1;
    rng = 32'h0000_8F6F;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rdExp(ADDR_PATH_CFG, PATH_CFG_RESET, '1);
    rdExp(ADDR_OUT_CTRL, OUT_CTRL_RESET, '1);
    rdExp(ADDR_FSYNC_CFG, FSYNC_CFG_RESET, '1);
    busReq(4'h2, 1'b0, '1, 4'hF);
    rdExp(4'h2, '0, '1);
    repeat (4) begin
      rng = nextRand(rng);
      busReq(ADDR_FSYNC_CFG, 1'b0, rng, 4'hF);
      rdExp(ADDR_FSYNC_CFG, {28'h0, rng[3:0]}, '1);
    end
    busReq(ADDR_FSYNC_CFG, 1'b0, ~rng, 4'h0);
    rdExp(ADDR_FSYNC_CFG, {28'h0, rng[3:0]}, '1);
    busReq(ADDR_STATUS, 1'b0, '0, 4'hF);
    rdExp(ADDR_STATUS, 32'h0000_0020, 32'h0000_0020);
    $display("registers done");
    for (int p = 1; p >= 0; p--) begin
      busReq(ADDR_PATH_CFG, 1'b0, 32'(p), 4'h1);
      span(0, 1'b1, n);
      span(0, 1'b1, n);
      check(32'(n), 32'(SRC / (p ? 128_000 : 64_000)));
    end
    busReq(ADDR_OUT_CTRL, 1'b0, 32'h0000_0001, 4'h1);
    busReq(ADDR_PATH_CFG, 1'b0, 32'h0000_0002, 4'h1);
    secRefValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rises(0, 400, n);
    check(32'(n), 32'h0);
    rises(1, 100, n);
    check(32'(n), 32'h0);
    rdExp(ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    secRefValid <= 1'b1;
    span(0, 1'b1, n);
    check(32'(n), 32'(SRC / 64_000));
    $display("composite done");
    for (int c = 0; c < 4; c++) begin
      // The unused rate bit is set opposite to catch a wrong source
      cfg = c[1] ? {c[0], !c[0], 2'b01} : {!c[0], c[0], 2'b00};
      busReq(ADDR_PATH_CFG, 1'b0, {28'h0, cfg}, 4'h1);
      repeat (20) @(posedge ref_clk);
      rises(1, 3072, n);
      near(n, int'(longint'(c[1] ? 3072 : 1536) * (c[0] ? DS1_HZ : E1_HZ) / SRC));
    end
    busReq(ADDR_OUT_CTRL, 1'b0, 32'h0000_0000, 4'h1);
    repeat (3) @(posedge ref_clk);
    rises(1, 200, n);
    check(32'(n), 32'h0);
    $display("rate clock done");
    busReq(ADDR_FSYNC_CFG, 1'b0, 32'h0000_0000, 4'hF);
    busReq(ADDR_OUT_CTRL, 1'b0, 32'h0000_0006, 4'h1);
    span(2, 1'b1, n);
    check(32'(n), 32'(H8));
    span(3, 1'b1, n);
    check(32'(n), 32'(4 * H8));
    for (int k = 0; k < 2; k++) begin
      busReq(ADDR_FSYNC_CFG, 1'b0, k ? 32'h0000_000F : 32'h0000_0005, 4'h1);
      // A pulse under way when the mode flips comes out short
      repeat (30) @(posedge ref_clk);
      span(2, k[0], n);
      near(n, WCYC);
      span(2, !k[0], n);
      near(n, 2 * H8 - WCYC);
      span(3, k[0], n);
      near(n, WCYC);
      span(3, !k[0], n);
      near(n, 8 * H8 - WCYC);
    end
    busReq(ADDR_OUT_CTRL, 1'b0, 32'h0000_0000, 4'h1);
    repeat (3) @(posedge ref_clk);
    check({29'h0, outs[3:1]}, 32'h0);
    rises(2, 300, n);
    check(32'(n), 32'h0);
    $display("frame outputs done");
    giveVerdict();
  end
endmodule : low_rate_output_clock_gen_tb
